/* File: rtl/amp_regs.svh */
// register offsets, field positions and limits for the programming port
`ifndef AMP_REGS_SVH
`define AMP_REGS_SVH

// input image word indices
`define AMP_STATUS_WORD_LOW        11'h000
`define AMP_STATUS_WORD_HIGH       11'h001
`define AMP_MOTOR_POSITION_FIRST   11'h002
`define AMP_MOTOR_POSITION_SECOND  11'h003
`define AMP_ENCODER_POSITION_FIRST 11'h004
`define AMP_ENCODER_POSITION_SEC   11'h005
`define AMP_CAPTURED_POSITION_FIRST 11'h006
`define AMP_CAPTURED_POSITION_SEC  11'h007
`define AMP_PROGRAMMED_CURRENT_X10 11'h008
`define AMP_JERK_READBACK          11'h009
`define AMP_IMG_WORDS              10

// command block word indices
`define AMP_COMMAND_WORD_LOW       11'h400
`define AMP_COMMAND_WORD_HIGH      11'h401
`define AMP_SEGMENT_TARGET_UPPER   11'h402
`define AMP_SEGMENT_TARGET_LOWER   11'h403
`define AMP_SEGMENT_SPEED_UPPER    11'h404
`define AMP_SEGMENT_SPEED_LOWER    11'h405
`define AMP_SEGMENT_ACCELERATION   11'h406
`define AMP_SEGMENT_DECELERATION   11'h407
`define AMP_SEGMENT_RESERVED       11'h408
`define AMP_SEGMENT_JERK           11'h409

// command and status bit positions
`define AMP_HCW_ASSY_BIT           11
`define AMP_HCW_SEG_BIT            12
`define AMP_HCW_RUN_BIT            13
`define AMP_CW1_DWELL_BIT          9
`define AMP_CW1_RESET_ERR_BIT      10
`define AMP_ST_IN_ASSY_BIT         8
`define AMP_ST_WAIT_SEG_BIT        9
`define AMP_ST_CMD_ERR_BIT         12

// codes and limits
`define AMP_FIRST_BLOCK_CODE       16'h0800
`define AMP_SEGMENT_CODE           16'h1800
`define AMP_MAX_SEGMENTS           5'h10
`define AMP_TARGET_LIMIT           32'sd8388607
`define AMP_SPEED_MAX              32'sd2999999
`define AMP_RAMP_MIN               32'sd1
`define AMP_RAMP_MAX               32'sd5000
`define AMP_JERK_MAX               32'sd5000
`define AMP_MW_DIVISOR             32'sd1000

`endif

/* File: rtl/amp_pkg.sv */
// types for the assembled move programming port
package amp_pkg;

  typedef logic [15:0] amp_word_t;

  typedef enum logic [1:0] {
    AMP_IDLE = 2'b00,
    AMP_WAIT = 2'b01,
    AMP_ACK  = 2'b10
  } amp_state_t;

endpackage : amp_pkg

/* File: rtl/amp_port.sv */
// assembled move programming port and command mode input image
`timescale 1ns/1ps
`include "amp_regs.svh"

// Notes on behaviour
// - move type chosen only at run start
// - unused and reserved words are ignored
// - first block sets in-mode and waiting bits
// - segment bit set: capture unless sixteen stored, clear waiting
// - segment bit clear: raise waiting again
// - sixteen segments stored at most
// - ten input words in fixed order
// - format bit selects multi-word or binary
// - thousands first, signed remainder second
// - multi-word undefined outside its range
// - word order selects which half first
// - waiting bit means next segment accepted unless sixteen are stored
module amp_port
  import amp_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire logic               wr_en_i,
  input  wire logic [10:0]        wr_addr_i,
  input  wire logic [15:0]        wr_data_i,
  input  wire logic [10:0]        rd_addr_i,
  output logic      [15:0]        rd_data_o,
  input  wire logic [15:0]        status_ext_low_i,
  input  wire logic [15:0]        status_ext_high_i,
  input  wire logic signed [31:0] motor_pos_i,
  input  wire logic signed [31:0] encoder_pos_i,
  input  wire logic signed [31:0] captured_pos_i,
  input  wire logic [15:0]        current_x10_i,
  input  wire logic [15:0]        jerk_param_i,
  input  wire logic               binary_format_i,
  input  wire logic               big_endian_i,
  input  wire logic [31:0]        start_speed_i,
  input  wire logic [3:0]         seg_rd_idx_i,
  output logic      [31:0]        seg_target_o,
  output logic      [31:0]        seg_speed_o,
  output logic      [15:0]        seg_accel_o,
  output logic      [15:0]        seg_decel_o,
  output logic      [15:0]        seg_jerk_o,
  output logic      [4:0]         seg_count_o,
  output logic                    run_start_o,
  output logic                    run_dwell_o
);

  amp_word_t  cmd_r [`AMP_IMG_WORDS];
  amp_word_t  img_r [`AMP_IMG_WORDS];
  amp_state_t state_r;
  logic       in_assy_r;
  logic       wait_seg_r;
  logic       cmd_err_r;
  logic [4:0] seg_cnt_r;
  logic       run_prev_r;
  logic [31:0] seg_tgt_mem [16];
  logic [31:0] seg_spd_mem [16];
  logic [15:0] seg_acc_mem [16];
  logic [15:0] seg_dec_mem [16];
  logic [15:0] seg_jrk_mem [16];

  function automatic logic in_rng(input logic signed [31:0] v,
                                  input logic signed [31:0] lo,
                                  input logic signed [31:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng

  function automatic logic [31:0] pos_fmt(input logic signed [31:0] v,
                                          input logic bin,
                                          input logic big);
    logic signed [31:0] q;
    logic signed [31:0] r;
    q = v / `AMP_MW_DIVISOR;
    r = v % `AMP_MW_DIVISOR;
    if (!bin) begin
      pos_fmt = {q[15:0], r[15:0]};
    end else if (big) begin
      pos_fmt = {v[31:16], v[15:0]};
    end else begin
      pos_fmt = {v[15:0], v[31:16]};
    end
  endfunction : pos_fmt

  function automatic logic is_cmd(input logic [10:0] a);
    is_cmd = (a >= `AMP_COMMAND_WORD_LOW) && (a <= `AMP_SEGMENT_JERK);
  endfunction : is_cmd

  // command word fields
  logic               hcw_assy;
  logic               hcw_seg;
  logic               hcw_run;
  logic               first_blk;
  logic               seg_req;
  logic               seg_full;
  logic signed [31:0] seg_tgt;
  logic signed [31:0] seg_spd;
  logic               seg_ok;
  logic [31:0]        motor_w;
  logic [31:0]        enc_w;
  logic [31:0]        capt_w;
  logic [3:0]         wr_idx;

  assign hcw_assy  = cmd_r[0][`AMP_HCW_ASSY_BIT];
  assign hcw_seg   = cmd_r[0][`AMP_HCW_SEG_BIT];
  assign hcw_run   = cmd_r[0][`AMP_HCW_RUN_BIT];
  assign first_blk = (cmd_r[0] == `AMP_FIRST_BLOCK_CODE);
  assign seg_req   = (state_r == AMP_WAIT) && hcw_seg;
  assign seg_full  = (seg_cnt_r == `AMP_MAX_SEGMENTS);
  assign seg_tgt   = {cmd_r[2], cmd_r[3]};
  assign seg_spd   = {cmd_r[4], cmd_r[5]};
  assign wr_idx    = 4'(wr_addr_i - `AMP_COMMAND_WORD_LOW);
  assign motor_w   = pos_fmt(motor_pos_i, binary_format_i, big_endian_i);
  assign enc_w     = pos_fmt(encoder_pos_i, binary_format_i, big_endian_i);
  assign capt_w    = pos_fmt(captured_pos_i, binary_format_i, big_endian_i);

  // reserved word 8 never checked
  assign seg_ok = in_rng(seg_tgt, -`AMP_TARGET_LIMIT, `AMP_TARGET_LIMIT)
    && in_rng(seg_spd, $signed(start_speed_i), `AMP_SPEED_MAX)
    && in_rng({16'h0000, cmd_r[6]}, `AMP_RAMP_MIN, `AMP_RAMP_MAX)
    && in_rng({16'h0000, cmd_r[7]}, `AMP_RAMP_MIN, `AMP_RAMP_MAX)
    && in_rng({16'h0000, cmd_r[9]}, 32'sd0, `AMP_JERK_MAX);

  // command block words written by the host
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `AMP_IMG_WORDS; i++) begin
        cmd_r[i] <= 16'h0000;
      end
    end else if (wr_en_i && is_cmd(wr_addr_i)) begin
      cmd_r[wr_idx] <= wr_data_i;
    end
  end

  // assembled programming handshake
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r    <= AMP_IDLE;
      in_assy_r  <= 1'b0;
      wait_seg_r <= 1'b0;
      seg_cnt_r  <= 5'h00;
    end else begin
      case (state_r)
        AMP_IDLE: begin
          if (first_blk) begin
            state_r    <= AMP_WAIT;
            in_assy_r  <= 1'b1;
            wait_seg_r <= 1'b1;
            seg_cnt_r  <= 5'h00;
          end
        end
        AMP_WAIT: begin
          if (hcw_seg) begin
            state_r    <= AMP_ACK;
            wait_seg_r <= 1'b0;
            if (!seg_full) begin
              seg_cnt_r <= seg_cnt_r + 5'h01;
            end
          end else if (!hcw_assy) begin
            state_r    <= AMP_IDLE;
            in_assy_r  <= 1'b0;
            wait_seg_r <= 1'b0;
          end
        end
        AMP_ACK: begin
          if (!hcw_seg) begin
            state_r    <= AMP_WAIT;
            wait_seg_r <= 1'b1;
          end
        end
        default: begin
          state_r    <= AMP_IDLE;
          in_assy_r  <= 1'b0;
          wait_seg_r <= 1'b0;
        end
      endcase
    end
  end

  // segment storage
  always_ff @(posedge core_clk_i) begin
    if (seg_req && !seg_full) begin
      seg_tgt_mem[seg_cnt_r[3:0]] <= seg_tgt;
      seg_spd_mem[seg_cnt_r[3:0]] <= seg_spd;
      seg_acc_mem[seg_cnt_r[3:0]] <= cmd_r[6];
      seg_dec_mem[seg_cnt_r[3:0]] <= cmd_r[7];
      seg_jrk_mem[seg_cnt_r[3:0]] <= cmd_r[9];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      seg_target_o <= 32'h0000_0000;
      seg_speed_o  <= 32'h0000_0000;
      seg_accel_o  <= 16'h0000;
      seg_decel_o  <= 16'h0000;
      seg_jerk_o   <= 16'h0000;
    end else if (seg_rd_idx_i < seg_cnt_r) begin
      seg_target_o <= seg_tgt_mem[seg_rd_idx_i];
      seg_speed_o  <= seg_spd_mem[seg_rd_idx_i];
      seg_accel_o  <= seg_acc_mem[seg_rd_idx_i];
      seg_decel_o  <= seg_dec_mem[seg_rd_idx_i];
      seg_jerk_o   <= seg_jrk_mem[seg_rd_idx_i];
    end else begin
      seg_target_o <= 32'h0000_0000;
      seg_speed_o  <= 32'h0000_0000;
      seg_accel_o  <= 16'h0000;
      seg_decel_o  <= 16'h0000;
      seg_jerk_o   <= 16'h0000;
    end
  end

  assign seg_count_o = seg_cnt_r;

  // command error flag, set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmd_err_r <= 1'b0;
    end else if (seg_req && (seg_full || !seg_ok)) begin
      cmd_err_r <= 1'b1;
    end else if (cmd_r[1][`AMP_CW1_RESET_ERR_BIT]) begin
      cmd_err_r <= 1'b0;
    end
  end

  // run start: blend or dwell from command word 1
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      run_prev_r  <= 1'b0;
      run_start_o <= 1'b0;
      run_dwell_o <= 1'b0;
    end else begin
      run_prev_r  <= hcw_run;
      run_start_o <= hcw_run && !run_prev_r;
      if (hcw_run && !run_prev_r) begin
        run_dwell_o <= cmd_r[1][`AMP_CW1_DWELL_BIT];
      end
    end
  end

  // input image, all words from one sample
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `AMP_IMG_WORDS; i++) begin
        img_r[i] <= 16'h0000;
      end
    end else begin
      img_r[0] <= {status_ext_low_i[15:13], cmd_err_r,
                   status_ext_low_i[11:10], wait_seg_r, in_assy_r,
                   status_ext_low_i[7:0]};
      img_r[1] <= status_ext_high_i;
      img_r[2] <= motor_w[31:16];
      img_r[3] <= motor_w[15:0];
      img_r[4] <= enc_w[31:16];
      img_r[5] <= enc_w[15:0];
      img_r[6] <= capt_w[31:16];
      img_r[7] <= capt_w[15:0];
      img_r[8] <= current_x10_i;
      img_r[9] <= jerk_param_i;
    end
  end

  // register read port
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_data_o <= 16'h0000;
    end else if (rd_addr_i <= `AMP_JERK_READBACK) begin
      rd_data_o <= img_r[rd_addr_i[3:0]];
    end else if (is_cmd(rd_addr_i)) begin
      rd_data_o <= cmd_r[4'(rd_addr_i - `AMP_COMMAND_WORD_LOW)];
    end else begin
      rd_data_o <= 16'h0000;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  first_block_a: assert property (
    (state_r == AMP_IDLE) && first_blk |=> in_assy_r && wait_seg_r)
    else $error("first block did not raise mode bits");

  seg_ack_a: assert property (
    seg_req |=> !wait_seg_r && (state_r == AMP_ACK))
    else $error("segment not acknowledged");

  seg_rearm_a: assert property (
    (state_r == AMP_ACK) && !hcw_seg |=> wait_seg_r)
    else $error("waiting bit not raised again");

  seg_count_a: assert property (
    seg_req && !seg_full |=> seg_cnt_r == $past(seg_cnt_r) + 5'h01)
    else $error("segment count did not advance");

  seg_limit_a: assert property (
    seg_cnt_r <= `AMP_MAX_SEGMENTS)
    else $error("segment count above limit");

  range_error_a: assert property (
    seg_req && !seg_ok |=> cmd_err_r [*2])
    else $error("range error not flagged");

  run_type_a: assert property (
    $rose(hcw_run) |=> run_start_o && (run_dwell_o ==
      $past(cmd_r[1][`AMP_CW1_DWELL_BIT])))
    else $error("move type not taken at start");

  little_endian_a: assert property (
    binary_format_i && !big_endian_i |=>
      img_r[2] == $past(motor_pos_i[15:0]))
    else $error("little endian low word not first");

  multi_word_a: assert property (
    !binary_format_i |=>
      img_r[3] == 16'($past(motor_pos_i) % `AMP_MW_DIVISOR))
    else $error("multi-word remainder wrong");

  wait_mode_a: assert property (
    wait_seg_r |-> in_assy_r && (img_r[0][`AMP_ST_IN_ASSY_BIT] ||
      !$past(in_assy_r)))
    else $error("waiting bit outside assembled mode");

  first_block_c: cover property ((state_r == AMP_IDLE) && first_blk);
  segment_c: cover property (seg_req ##1 (state_r == AMP_ACK)
    ##[1:20] (state_r == AMP_WAIT));
  full_c: cover property (seg_full && seg_req);
  run_c: cover property (run_start_o && run_dwell_o);

endmodule : amp_port

/* File: verif/amp_host_model.sv */
// host controller model driving the command block
`timescale 1ns/1ps
module amp_host_model (
  input  wire logic        core_clk_i,
  input  wire logic [15:0] rd_data_i,
  output logic             wr_en_o,
  output logic      [10:0] wr_addr_o,
  output logic      [15:0] wr_data_o,
  output logic      [10:0] rd_addr_o
);
  initial begin
    wr_en_o = 1'b0;
    wr_addr_o = 11'h000;
    wr_data_o = 16'h0000;
    rd_addr_o = 11'h000;
  end
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    wr_en_o <= 1'b1;
    wr_addr_o <= a;
    wr_data_o <= d;
    @(posedge core_clk_i);
    wr_en_o <= 1'b0;
    wr_data_o <= ~d;
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    rd_addr_o <= a;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    d = rd_data_i;
  endtask : rd
  task automatic poll(input int b, input logic v, output logic ok);
    logic [15:0] d;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(11'h000, d);
      ok = (d[b] === v);
    end
  endtask : poll
  task automatic first_block(output logic ok);
    logic a;
    wr(11'h400, 16'h0800);
    poll(8, 1'b1, a);
    poll(9, 1'b1, ok);
    ok = ok & a;
  endtask : first_block
  task automatic segment(input logic [31:0] tg, input logic [31:0] sp,
    input logic [15:0] ac, input logic [15:0] rs, output logic ok);
    logic a;
    wr(11'h402, tg[31:16]);
    wr(11'h403, tg[15:0]);
    wr(11'h404, sp[31:16]);
    wr(11'h405, sp[15:0]);
    wr(11'h406, ac);
    wr(11'h407, 16'h0001);
    wr(11'h408, rs);
    wr(11'h409, 16'h0000);
    wr(11'h400, 16'h1800);
    poll(9, 1'b0, a);
    wr(11'h400, 16'h0800);
    poll(9, 1'b1, ok);
    ok = ok & a;
  endtask : segment
endmodule : amp_host_model

/* File: verif/assembled_move_programming_port_tb.sv */
// self-checking bench for the programming port
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module assembled_move_programming_port_tb;
  logic               core_clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               wr_en_i;
  logic        [10:0] wr_addr_i, rd_addr_i;
  logic        [15:0] wr_data_i, rd_data_o;
  logic        [15:0] status_ext_low_i = 16'h0003;
  logic        [15:0] status_ext_high_i = 16'h0000;
  logic signed [31:0] motor_pos_i = 0, encoder_pos_i = 0;
  logic signed [31:0] captured_pos_i = 0;
  logic        [15:0] current_x10_i = 16'h0000, jerk_param_i = 16'h0000;
  logic               binary_format_i = 1'b0, big_endian_i = 1'b0;
  logic        [31:0] start_speed_i = 32'h0000_03E8;
  logic        [3:0]  seg_rd_idx_i = 4'h0;
  logic        [31:0] seg_target_o, seg_speed_o;
  logic        [15:0] seg_accel_o, seg_decel_o, seg_jerk_o;
  logic        [4:0]  seg_count_o;
  logic               run_start_o, run_dwell_o;
  int fail_count = 0, compares = 0, cycles = 0, runs = 0;
  localparam logic [15:0] EXP_IMG [0:2][0:9] = '{
    '{16'h1003, 16'hA5A5, 16'h04D2, 16'h0237, 16'hE21A, 16'hFEBF,
      16'h0000, 16'hFFF4, 16'h0028, 16'h1388},
    '{16'h1003, 16'hA5A5, 16'hD687, 16'h0012, 16'h344F, 16'hFF8B,
      16'hFFF4, 16'hFFFF, 16'h0028, 16'h1388},
    '{16'h1003, 16'hA5A5, 16'h0012, 16'hD687, 16'hFF8B, 16'h344F,
      16'hFFFF, 16'hFFF4, 16'h0028, 16'h1388}};

  amp_port u_amp_port (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .status_ext_low_i(status_ext_low_i),
    .status_ext_high_i(status_ext_high_i), .motor_pos_i(motor_pos_i),
    .encoder_pos_i(encoder_pos_i), .captured_pos_i(captured_pos_i),
    .current_x10_i(current_x10_i), .jerk_param_i(jerk_param_i),
    .binary_format_i(binary_format_i), .big_endian_i(big_endian_i),
    .start_speed_i(start_speed_i), .seg_rd_idx_i(seg_rd_idx_i),
    .seg_target_o(seg_target_o), .seg_speed_o(seg_speed_o),
    .seg_accel_o(seg_accel_o), .seg_decel_o(seg_decel_o),
    .seg_jerk_o(seg_jerk_o), .seg_count_o(seg_count_o),
    .run_start_o(run_start_o), .run_dwell_o(run_dwell_o));

  amp_host_model u_amp_host_model (.core_clk_i(core_clk_i),
    .rd_data_i(rd_data_o), .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i),
    .wr_data_o(wr_data_i), .rd_addr_o(rd_addr_i));

  always #25 core_clk_i = ~core_clk_i;

  always @(posedge core_clk_i) begin
    cycles++;
    if (run_start_o === 1'b1) runs++;
    if (cycles == 8000) begin
      fail_count++;
      results();
    end
  end

  task automatic results;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic t_seg(input logic [31:0] tg, input logic [15:0] ac,
                       input logic [15:0] rs, input logic er);
    logic ok;
    logic [15:0] d;
    u_amp_host_model.segment(tg, 32'h0001_86A0, ac, rs, ok);
    `CHK(ok, 1'b1)
    u_amp_host_model.rd(11'h000, d);
    `CHK(d[12], er)
  endtask : t_seg

  task automatic t_reset;
    logic [15:0] d;
    u_amp_host_model.rd(11'h000, d);
    `CHK(d, 16'h0003)
    `CHK(seg_count_o, 5'h00)
  endtask : t_reset

  task automatic t_first;
    logic ok;
    u_amp_host_model.first_block(ok);
    `CHK(ok, 1'b1)
  endtask : t_first

  task automatic t_seg_ok;
    t_seg(32'hFFFE_7960, 16'h1388, 16'h1234, 1'b0);
    @(posedge core_clk_i);
    seg_rd_idx_i <= 4'h0;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    `CHK(seg_count_o, 5'h01)
    `CHK(seg_target_o, 32'hFFFE_7960)
    `CHK(seg_speed_o, 32'h0001_86A0)
    `CHK(seg_accel_o, 16'h1388)
    `CHK(seg_decel_o, 16'h0001)
    `CHK(seg_jerk_o, 16'h0000)
  endtask : t_seg_ok

  task automatic t_seg_bad;
    logic [15:0] d;
    t_seg(32'h0000_0064, 16'h0000, 16'h0000, 1'b1);
    u_amp_host_model.wr(11'h401, 16'h0400);
    u_amp_host_model.wr(11'h401, 16'h0000);
    u_amp_host_model.rd(11'h000, d);
    `CHK(d[12], 1'b0)
  endtask : t_seg_bad

  task automatic t_full;
    for (int i = 0; i < 14; i++)
      t_seg(32'h0000_0064, 16'h0001, 16'h0000, 1'b0);
    `CHK(seg_count_o, 5'h10)
    t_seg(32'h0000_0064, 16'h0001, 16'h0000, 1'b1);
    `CHK(seg_count_o, 5'h10)
  endtask : t_full

  task automatic t_run;
    int r0;
    for (int dw = 1; dw >= 0; dw--) begin
      r0 = runs;
      u_amp_host_model.wr(11'h401, dw[0] ? 16'h0200 : 16'h0000);
      u_amp_host_model.wr(11'h400, 16'h2000);
      u_amp_host_model.wr(11'h401, dw[0] ? 16'h0000 : 16'h0200);
      u_amp_host_model.wr(11'h400, 16'h0000);
      `CHK(runs - r0, 1)
      `CHK(run_dwell_o, dw[0])
    end
  endtask : t_run

  task automatic t_image;
    logic [15:0] d;
    @(posedge core_clk_i);
    status_ext_high_i <= 16'hA5A5;
    motor_pos_i <= 32'sd1234567;
    encoder_pos_i <= -32'sd7654321;
    captured_pos_i <= -32'sd12;
    current_x10_i <= 16'h0028;
    jerk_param_i <= 16'h1388;
    for (int m = 0; m < 3; m++) begin
      @(posedge core_clk_i);
      binary_format_i <= (m != 0);
      big_endian_i <= (m == 2);
      for (int i = 0; i < 10; i++) begin
        u_amp_host_model.rd(11'(i), d);
        `CHK(d, EXP_IMG[m][i])
      end
    end
  endtask : t_image

  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_first;
    t_seg_ok;
    t_seg_bad;
    t_full;
    t_run;
    t_image;
    results;
  end
endmodule : assembled_move_programming_port_tb
